// file: core/hac_pkg.sv
// Package: constants, register map and types for histogram acquisition control
package hac_pkg;
  // ======================================================
  // Register byte offsets
  localparam logic [7:0] HAC_CTRL_OFS = 8'h00;
  localparam logic [7:0] HAC_THRESH_OFS = 8'h04;
  localparam logic [7:0] HAC_PRESET_TIME_OFS = 8'h08;
  localparam logic [7:0] HAC_PRESET_CNT_OFS = 8'h0C;
  localparam logic [7:0] HAC_STATUS_OFS = 8'h10;
  localparam logic [7:0] HAC_ACC_TIME_OFS = 8'h14;
  localparam logic [7:0] HAC_ROI_CNT_OFS = 8'h18;
  localparam logic [7:0] HAC_WIN_BASE_OFS = 8'h20;
  localparam logic [31:0] HAC_UNMAPPED_READ = 32'h0000_0000;
  // ======================================================
  // Control register field positions
  localparam int HAC_CTRL_START_BIT = 0;
  localparam int HAC_CTRL_STOP_BIT = 1;
  localparam int HAC_CTRL_SIZE_LSB = 4;
  localparam int HAC_CTRL_GATE_EN_BIT = 8;
  localparam int HAC_CTRL_GATE_POL_BIT = 9;
  localparam int HAC_CTRL_BUF_SEL_BIT = 12;
  localparam int HAC_CTRL_HW_SEL_BIT = 13;
  // Window register fields
  localparam int HAC_WIN_LO_LSB = 0;
  localparam int HAC_WIN_HI_LSB = 16;
  localparam int HAC_WIN_EN_BIT = 31;
  // ======================================================
  // Sizes and reset values
  localparam int HAC_PEAK_W = 16;
  localparam int HAC_CHAN_W = 13;
  localparam int HAC_NUM_WIN = 8;
  localparam logic [2:0] HAC_SIZE_RESET = 3'h2;
  localparam logic [2:0] HAC_SIZE_MAX = 3'h5;
  localparam logic [7:0] HAC_THRESH_RESET = 8'h00;
  // ======================================================
  // Timing
  localparam int HAC_CLK_MHZ = 250;
  localparam int HAC_TICK_MS = 100;
  localparam int HAC_TICK_CYCLES = HAC_TICK_MS * 1000 * HAC_CLK_MHZ;
  localparam int HAC_PULSE_NS = 50;
  localparam int HAC_PULSE_CYCLES = (HAC_PULSE_NS * HAC_CLK_MHZ) / 1000;
  localparam int HAC_PRESET_TIME_W = 24;
  localparam int HAC_CNT_W = 32;

  // Qualified binned event
  typedef struct packed {
    logic valid;
    logic buf_b;
    logic [HAC_CHAN_W-1:0] chan;
  } hac_event_s;

  typedef enum logic [1:0] {HAC_IDLE, HAC_RUN, HAC_DONE} hac_state_e;
endpackage

// file: core/hac_top.sv
// Histogram acquisition control: qualification, binning, presets, windows
// Function
// - Size 256..8192 channels, peaks scaled down
// - Bin only peaks above low threshold
// - Threshold 8 bits, up to quarter scale
// - Gate off ignores external gate input
// - Gate polarity selectable, record while active
// - Two buffers A and B, software selects
// - Hardware select input picks buffer
// - Preset time 100 ms steps, long range
// - Stop when accumulation time reaches preset
// - Time advances only while acquiring
// - Stop when region count reaches preset
// - Region is window discriminator eight range
// - Eight windows with enable, lower, upper
// - Disabled window stays silent
// - Window limits in histogram channels
// - One pulse per in-range binned event
// - Window pulse about 50 ns wide
// - Acquisition enable flag mirrors accumulation state
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
module hac_top
  import hac_pkg::*;
#(
  parameter int TICK_CYCLES = HAC_TICK_CYCLES,
  parameter int PULSE_CYCLES = HAC_PULSE_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic peak_valid,
  input wire logic [HAC_PEAK_W-1:0] peak_value,
  input wire logic gate_in,
  input wire logic buffer_select_in,
  output logic bin_valid,
  output logic bin_buffer_b,
  output logic [HAC_CHAN_W-1:0] bin_channel,
  output logic acquisition_enable_flag,
  output logic [HAC_NUM_WIN-1:0] window_discriminator
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  initial
  begin
    if (TICK_CYCLES < 1)
      $error("tick period must be at least one cycle");
    if (HAC_PEAK_W < HAC_CHAN_W)
      $error("peak width must cover the largest histogram");
  end

  // ======================================================
  // Configuration registers
  logic [2:0] size_r;
  logic gate_en_r;
  logic gate_pol_r;
  logic buf_sel_r;
  logic hw_sel_r;
  logic [7:0] thresh_r;
  logic [HAC_PRESET_TIME_W-1:0] preset_time_r;
  logic [HAC_CNT_W-1:0] preset_cnt_r;
  logic [HAC_NUM_WIN-1:0] win_en_r;
  logic [HAC_CHAN_W-1:0] win_lo_r [HAC_NUM_WIN];
  logic [HAC_CHAN_W-1:0] win_hi_r [HAC_NUM_WIN];
  logic start_req;
  logic stop_req;
  logic time_hit;
  logic count_hit;

  // Acquisition state
  hac_state_e state_r;
  logic [TW-1:0] tick_div_r;
  logic tick;
  logic [HAC_PRESET_TIME_W-1:0] acc_time_r;
  logic [HAC_CNT_W-1:0] roi_cnt_r;
  logic running;

  // ======================================================
  // Bus decode
  logic wr_access;
  logic rd_access;
  logic ctrl_wr;
  logic [2:0] win_idx;
  logic win_wr;

  // Slave answers with waitrequest low one cycle after the request rises
  assign wr_access = avs_write && !avs_waitrequest;
  // Read data loads while the request waits, so it stands when waitrequest drops
  assign rd_access = avs_read && avs_waitrequest;
  assign win_idx = avs_address[4:2];
  assign win_wr = wr_access && (avs_address[7:5] == HAC_WIN_BASE_OFS[7:5]);
  assign ctrl_wr = wr_access && (avs_address == HAC_CTRL_OFS);
  assign start_req = ctrl_wr && avs_byteenable[0] && avs_writedata[HAC_CTRL_START_BIT];
  assign stop_req = ctrl_wr && avs_byteenable[0] && avs_writedata[HAC_CTRL_STOP_BIT];

  // Waitrequest drops for one cycle per request
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
  end

  // Control register fields
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      size_r <= HAC_SIZE_RESET;
      gate_en_r <= 1'b0;
      gate_pol_r <= 1'b0;
      buf_sel_r <= 1'b0;
      hw_sel_r <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      // size select
      // Out of range codes are clamped to the largest histogram
      if (avs_byteenable[0])
        size_r <= (avs_writedata[HAC_CTRL_SIZE_LSB +: 3] > HAC_SIZE_MAX) ? HAC_SIZE_MAX :
                  avs_writedata[HAC_CTRL_SIZE_LSB +: 3];
      if (avs_byteenable[1])
      begin
        gate_en_r <= avs_writedata[HAC_CTRL_GATE_EN_BIT];
        gate_pol_r <= avs_writedata[HAC_CTRL_GATE_POL_BIT];
        buf_sel_r <= avs_writedata[HAC_CTRL_BUF_SEL_BIT];
        hw_sel_r <= avs_writedata[HAC_CTRL_HW_SEL_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      thresh_r <= HAC_THRESH_RESET;
      preset_time_r <= '0;
      preset_cnt_r <= '0;
    end
    else if (wr_access)
    begin
      if (avs_address == HAC_THRESH_OFS && avs_byteenable[0])
        thresh_r <= avs_writedata[7:0];
      else if (avs_address == HAC_PRESET_TIME_OFS && avs_byteenable == 4'hF)
        preset_time_r <= avs_writedata[HAC_PRESET_TIME_W-1:0];
      else if (avs_address == HAC_PRESET_CNT_OFS && avs_byteenable == 4'hF)
        preset_cnt_r <= avs_writedata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < HAC_NUM_WIN; g++)
    begin : gen_win_reg
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          win_en_r[g] <= 1'b0;
          win_lo_r[g] <= '0;
          win_hi_r[g] <= '0;
        end
        else if (win_wr && win_idx == 3'(g) && avs_byteenable == 4'hF)
        begin
          win_en_r[g] <= avs_writedata[HAC_WIN_EN_BIT];
          win_lo_r[g] <= avs_writedata[HAC_WIN_LO_LSB +: HAC_CHAN_W];
          win_hi_r[g] <= avs_writedata[HAC_WIN_HI_LSB +: HAC_CHAN_W];
        end
      end
    end
  endgenerate

  // Read mux, registered; unmapped addresses read zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      avs_readdata <= '0;
    else if (rd_access)
    begin
      if (avs_address == HAC_CTRL_OFS)
        avs_readdata <= {18'h0, hw_sel_r, buf_sel_r, 2'h0, gate_pol_r, gate_en_r,
                         1'b0, size_r, 4'h0};
      else if (avs_address == HAC_THRESH_OFS)
        avs_readdata <= {24'h0, thresh_r};
      else if (avs_address == HAC_PRESET_TIME_OFS)
        avs_readdata <= 32'(preset_time_r);
      else if (avs_address == HAC_PRESET_CNT_OFS)
        avs_readdata <= preset_cnt_r;
      else if (avs_address == HAC_STATUS_OFS)
        avs_readdata <= {29'h0, state_r == HAC_DONE, buffer_select_in, running};
      else if (avs_address == HAC_ACC_TIME_OFS)
        avs_readdata <= 32'(acc_time_r);
      else if (avs_address == HAC_ROI_CNT_OFS)
        avs_readdata <= roi_cnt_r;
      else if (avs_address[7:5] == HAC_WIN_BASE_OFS[7:5])
        avs_readdata <= {win_en_r[win_idx], 2'h0, win_hi_r[win_idx], 3'h0, win_lo_r[win_idx]};
      else
        avs_readdata <= HAC_UNMAPPED_READ;
    end
  end

  // ======================================================
  // Acquisition state machine
  assign running = (state_r == HAC_RUN);
  // preset time stop; zero means no preset
  assign time_hit = (preset_time_r != '0) && (acc_time_r >= preset_time_r);
  // preset count stop; zero means no preset
  assign count_hit = (preset_cnt_r != '0) && (roi_cnt_r >= preset_cnt_r);

  // A stop request beats a simultaneous start
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state_r <= HAC_IDLE;
    else
    begin
      case (state_r)
        HAC_IDLE, HAC_DONE:
          if (start_req && !stop_req)
            state_r <= HAC_RUN;
        HAC_RUN:
          if (stop_req || time_hit || count_hit)
            state_r <= HAC_DONE;
        default:
          state_r <= HAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      acquisition_enable_flag <= 1'b0;
    else
      acquisition_enable_flag <= running;
  end

  // tick divider only runs while acquiring
  assign tick = running && (tick_div_r == TW'(TICK_CYCLES - 1));
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      tick_div_r <= '0;
    else if (start_req && !running)
      tick_div_r <= '0;
    else if (tick)
      tick_div_r <= '0;
    else if (running)
      tick_div_r <= tick_div_r + 1'b1;
  end

  // Accumulation time in 100 ms units, cleared on start
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      acc_time_r <= '0;
    else if (start_req && !running)
      acc_time_r <= '0;
    else if (tick)
      acc_time_r <= acc_time_r + 1'b1;
  end

  // ======================================================
  // Event qualification
  logic gate_ok;
  logic [HAC_CHAN_W-1:0] scaled;
  hac_event_s ev_r;
  logic [HAC_NUM_WIN-1:0] win_hit;
  logic [HAC_NUM_WIN-1:0] win_pulse;

  assign gate_ok = !gate_en_r || (gate_in == gate_pol_r);

  // scale peak to channel count
  // Keeps the top bits so full scale maps to the last channel of any size
  assign scaled = HAC_CHAN_W'(peak_value >> (HAC_PEAK_W - 8 - 32'(size_r)));

  // Binned event register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ev_r <= '0;
    else
    begin
      // low level threshold compare
      // Threshold 255 sits near a quarter of full scale
      ev_r.valid <= peak_valid && running && gate_ok &&
                    (peak_value[HAC_PEAK_W-1 -: 10] > {2'h0, thresh_r});
      ev_r.buf_b <= hw_sel_r ? buffer_select_in : buf_sel_r;
      ev_r.chan <= scaled;
    end
  end

  // Binning outputs to histogram memory
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bin_valid <= 1'b0;
      bin_buffer_b <= 1'b0;
      bin_channel <= '0;
    end
    else
    begin
      bin_valid <= ev_r.valid;
      bin_buffer_b <= ev_r.buf_b;
      bin_channel <= ev_r.chan;
    end
  end

  generate
    for (g = 0; g < HAC_NUM_WIN; g++)
    begin : gen_win
      hac_window_disc #(.PULSE_CYCLES(PULSE_CYCLES)) u_win (
        .clk(clk),
        .reset(reset),
        .enable(win_en_r[g]),
        .lower(win_lo_r[g]),
        .upper(win_hi_r[g]),
        .event_in(ev_r),
        .hit(win_hit[g]),
        .pulse(win_pulse[g])
      );
    end
  endgenerate
  assign window_discriminator = win_pulse;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      roi_cnt_r <= '0;
    else if (start_req && !running)
      roi_cnt_r <= '0;
    else if (win_hit[HAC_NUM_WIN-1] && roi_cnt_r != '1)
      roi_cnt_r <= roi_cnt_r + 1'b1;
  end
endmodule

// file: core/hac_window_disc.sv
// Single window discriminator with fixed-width output pulse
module hac_window_disc
  import hac_pkg::*;
#(
  parameter int PULSE_CYCLES = HAC_PULSE_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [HAC_CHAN_W-1:0] lower,
  input wire logic [HAC_CHAN_W-1:0] upper,
  input wire hac_event_s event_in,
  output logic hit,
  output logic pulse
);
  localparam int CW = $clog2(PULSE_CYCLES + 1);
  logic [CW-1:0] width_r;

  initial
  begin
    if (PULSE_CYCLES < 1)
      $error("pulse width must be at least one cycle");
  end

  always_comb
  begin
    hit = event_in.valid && enable && (event_in.chan >= lower) && (event_in.chan <= upper);
  end

  // fixed width pulse
  // Retrigger during a pulse restarts the width; events closer than 50 ns merge
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      width_r <= '0;
    else if (hit)
      width_r <= CW'(PULSE_CYCLES);
    else if (width_r != '0)
      width_r <= width_r - 1'b1;
  end

  // Registered output
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pulse <= 1'b0;
    else
      pulse <= hit || (width_r > CW'(1));
  end
endmodule

// file: verification/hac_monitor.sv
// Port checker for histogram acquisition control
module hac_monitor
  import hac_pkg::*;
#(
  parameter int TICK_CYCLES = HAC_TICK_CYCLES,
  parameter int PULSE_CYCLES = HAC_PULSE_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic peak_valid,
  input wire logic bin_valid,
  input wire logic acquisition_enable_flag,
  input wire logic [HAC_NUM_WIN-1:0] window_discriminator
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] since_r;
  logic [7:0] hi_r;
  // ======================================================
  // Cycles since last bin and length of the window one pulse
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      since_r <= 8'hFF;
    else if (bin_valid)
      since_r <= 8'h00;
    else if (since_r != 8'hFF)
      since_r <= since_r + 8'h01;
  end
  // Saturation not needed: a pulse is far shorter than 255 cycles
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      hi_r <= 8'h00;
    else
      hi_r <= window_discriminator[0] ? hi_r + 8'h01 : 8'h00;
  end
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer in one cycle");
  property p_wait_single;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_single: assert property (p_wait_single) else $error("waitrequest low too long");
  property p_read_hold;
    $changed(avs_readdata) |-> $past(avs_read) && $past(avs_waitrequest);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data changed unasked");
  property p_bin_cause;
    bin_valid |-> $past(peak_valid, 2);
  endproperty
  a_bin_cause: assert property (p_bin_cause) else $error("bin without peak");
  property p_win_cause;
    |(window_discriminator & ~$past(window_discriminator)) |-> bin_valid;
  endproperty
  a_win_cause: assert property (p_win_cause) else $error("window pulse without bin");
  property p_win_min;
    $fell(window_discriminator[0]) |-> hi_r >= PULSE_CYCLES;
  endproperty
  a_win_min: assert property (p_win_min) else $error("window pulse too short");
  property p_win_max;
    window_discriminator[0] && !bin_valid |-> since_r <= PULSE_CYCLES - 2;
  endproperty
  a_win_max: assert property (p_win_max) else $error("window pulse too long");
  property p_bin_idle;
    bin_valid |-> acquisition_enable_flag || $past(acquisition_enable_flag)
      || $past(acquisition_enable_flag, 2);
  endproperty
  a_bin_idle: assert property (p_bin_idle) else $error("bin while idle");
  property p_flag_start;
    $rose(acquisition_enable_flag) |-> $past(avs_write) || $past(avs_write, 2)
      || $past(avs_write, 3);
  endproperty
  a_flag_start: assert property (p_flag_start) else $error("start without write");
  c_bin: cover property (bin_valid);
  c_win8: cover property (window_discriminator[7]);
  c_stop: cover property ($fell(acquisition_enable_flag));
endmodule
bind hac_top hac_monitor #(.TICK_CYCLES(TICK_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) mon_u (
  .clk(clk),
  .reset(reset),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .peak_valid(peak_valid),
  .bin_valid(bin_valid),
  .acquisition_enable_flag(acquisition_enable_flag),
  .window_discriminator(window_discriminator)
);

// file: verification/hac_peak_source.sv
// Model of the shaper peak output and the external gate and select levels
module hac_peak_source
  import hac_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [HAC_PEAK_W-1:0] value,
  input wire logic gate_lvl,
  input wire logic sel_lvl,
  output logic peak_valid = 1'b0,
  output logic [HAC_PEAK_W-1:0] peak_value = 16'h0000,
  output logic gate_in = 1'b0,
  output logic buffer_select_in = 1'b0
);
  // ======================================================
  // One-cycle strobe; idle value lines toggle so stale data never looks valid
  always @(posedge clk)
  begin
    peak_valid <= go;
    peak_value <= go ? value : ~peak_value;
  end
  // select level driven
  // Levels launch with the peak, since the block samples them together
  always @(posedge clk)
  begin
    gate_in <= gate_lvl;
    buffer_select_in <= sel_lvl;
  end
endmodule

// file: verification/test_histogram_acquisition_control.sv
// Self-checking bench for histogram acquisition control
module test_histogram_acquisition_control
  import hac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic go = 1'b0;
  logic [15:0] value = 16'h0000;
  logic gate_lvl = 1'b0;
  logic sel_lvl = 1'b0;
  logic [31:0] rdata;
  logic wait_req, pv, gate_in, sel_in, bin_valid, bin_b, flag;
  logic [15:0] pval;
  logic [12:0] chan;
  logic [7:0] wd;
  int fail_count = 0;
  int cmp_count = 0;
  // ======================================================
  // Clock and design
  initial
  begin
    forever #2 clk = ~clk;
  end
  hac_top #(.TICK_CYCLES(10)) dut_u (.clk(clk), .reset(reset), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wait_req), .peak_valid(pv), .peak_value(pval),
    .gate_in(gate_in), .buffer_select_in(sel_in), .bin_valid(bin_valid),
    .bin_buffer_b(bin_b), .bin_channel(chan), .acquisition_enable_flag(flag),
    .window_discriminator(wd));
  hac_peak_source src_u (.clk(clk), .go(go), .value(value), .gate_lvl(gate_lvl),
    .sel_lvl(sel_lvl), .peak_valid(pv), .peak_value(pval), .gate_in(gate_in),
    .buffer_select_in(sel_in));
  // ======================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_req !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    // Answer due one cycle after the request is seen
    check("answer cycles", n, 32'h0000_0002);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check("register", q, exp);
  endtask
  // f holds hardware select, buffer B, gate polarity, gate enable
  function automatic logic [31:0] ctl(input logic [2:0] sz, input logic [3:0] f, input logic st);
    return {18'h0, f[3:2], 2'h0, f[1:0], 1'b0, sz, 3'h0, st};
  endfunction
  task automatic start(input logic [2:0] sz);
    wreg(HAC_CTRL_OFS, 32'h0000_0002);
    wreg(HAC_CTRL_OFS, ctl(sz, 4'h0, 1'b1));
  endtask
  // Peak sent, then bin and window outputs judged in the cycle they stand
  task automatic peak(input logic [15:0] v, input logic g, input logic s, input logic bin,
    input logic [12:0] ch, input logic b, input logic [7:0] win);
    @(posedge clk);
    go <= 1'b1;
    value <= v;
    gate_lvl <= g;
    sel_lvl <= s;
    @(posedge clk);
    go <= 1'b0;
    // Bin output stands for the cycle after the second edge past the strobe
    repeat (2) @(posedge clk);
    #1;
    check("bin_valid", bin_valid, bin);
    if (bin)
    begin
      check("channel", chan, ch);
      check("buffer", bin_b, b);
    end
    check("window", wd, win);
    repeat (14) @(posedge clk);
  endtask
  // ======================================================
  // Scenarios
  // threshold boundaries
  task automatic t_thresh;
    start(3'h2);
    wreg(HAC_THRESH_OFS, 32'h0000_0010);
    peak(16'h0400, 0, 0, 0, 13'h0, 0, 8'h00);
    peak(16'h0440, 0, 0, 1, 13'h011, 0, 8'h00);
    be <= 4'hE;
    wreg(HAC_THRESH_OFS, 32'h0000_00FF);
    be <= 4'hF;
    rchk(HAC_THRESH_OFS, 32'h0000_0010);
    wreg(HAC_THRESH_OFS, 32'h0000_00FF);
    peak(16'h3FC0, 0, 0, 0, 13'h0, 0, 8'h00);
    peak(16'h4000, 0, 0, 1, 13'h100, 0, 8'h00);
    wreg(HAC_THRESH_OFS, 32'h0000_0000);
  endtask
  task automatic t_size;
    for (int s = 0; s < 6; s++)
    begin
      wreg(HAC_CTRL_OFS, ctl(3'(s), 4'h0, 1'b0));
      peak(16'hFFC0, 0, 0, 1, 13'(16'hFFC0 >> (8 - s)), 0, 8'h00);
    end
  endtask
  task automatic t_gate;
    for (int i = 0; i < 6; i++)
    begin
      wreg(HAC_CTRL_OFS, ctl(3'h2, (i < 2) ? 4'h0 : (i < 4) ? 4'h3 : 4'h1, 1'b0));
      peak(16'h1000, i[0], 0, (i < 2) || (i[0] == (i < 4)), 13'h040, 0, 8'h00);
    end
  endtask
  task automatic t_buffer;
    for (int i = 0; i < 4; i++)
    begin
      wreg(HAC_CTRL_OFS, ctl(3'h2, (i == 0) ? 4'h0 : (i == 1) ? 4'h4 : 4'h8, 1'b0));
      peak(16'h1000, 0, (i == 0) || (i == 3), 1, 13'h040, (i == 1) || (i == 3), 8'h00);
    end
  endtask
  task automatic t_window;
    wreg(HAC_WIN_BASE_OFS, {1'b1, 2'h0, 13'd800, 3'h0, 13'd712});
    wreg(HAC_WIN_BASE_OFS + 8'h04, {1'b0, 2'h0, 13'd800, 3'h0, 13'd712});
    peak(16'd711 << 6, 0, 0, 1, 13'd711, 0, 8'h00);
    peak(16'd712 << 6, 0, 0, 1, 13'd712, 0, 8'h01);
    peak(16'd800 << 6, 0, 0, 1, 13'd800, 0, 8'h01);
    peak(16'd801 << 6, 0, 0, 1, 13'd801, 0, 8'h00);
    for (int i = 0; i < 8; i++)
      wreg(HAC_WIN_BASE_OFS + 8'(4 * i), {1'b1, 2'h0, 13'(16 * i + 12), 3'h0, 13'(16 * i + 10)});
    for (int i = 0; i < 8; i++)
      peak(16'(16 * i + 11) << 6, 0, 0, 1, 13'(16 * i + 11), 0, 8'h01 << i);
  endtask
  task automatic t_roi;
    wreg(HAC_WIN_BASE_OFS + 8'h1C, {1'b1, 2'h0, 13'd100, 3'h0, 13'd100});
    wreg(HAC_PRESET_CNT_OFS, 32'h0000_0003);
    start(3'h2);
    for (int i = 0; i < 3; i++)
      peak(16'h1900, 0, 0, 1, 13'd100, 0, 8'h80);
    check("flag", flag, 1'b0);
    rchk(HAC_ROI_CNT_OFS, 32'h0000_0003);
    peak(16'h1900, 0, 0, 0, 13'd100, 0, 8'h00);
    wreg(HAC_PRESET_CNT_OFS, 32'h0000_0000);
    start(3'h2);
    rchk(HAC_ROI_CNT_OFS, 32'h0000_0000);
  endtask
  task automatic t_time;
    wreg(HAC_CTRL_OFS, 32'h0000_0002);
    wreg(HAC_PRESET_TIME_OFS, 32'h0000_0003);
    start(3'h2);
    repeat (20) @(posedge clk);
    check("flag", flag, 1'b1);
    repeat (20) @(posedge clk);
    check("flag", flag, 1'b0);
    rchk(HAC_ACC_TIME_OFS, 32'h0000_0003);
    rchk(HAC_STATUS_OFS, 32'h0000_0004);
    repeat (50) @(posedge clk);
    rchk(HAC_ACC_TIME_OFS, 32'h0000_0003);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ======================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rchk(HAC_CTRL_OFS, 32'h0000_0020);
    rchk(8'hFC, HAC_UNMAPPED_READ);
    check("flag", flag, 1'b0);
    t_thresh;
    t_size;
    t_gate;
    t_buffer;
    t_window;
    t_roi;
    t_time;
    finish_test;
  end
  initial
  begin
    #40us;
    fail_count++;
    finish_test;
  end
endmodule
